// >>> design/ipbb_pkg.sv
// shared constants and types for the interleaved backplane bus block
package ipbb_pkg;
  // register port
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;
  localparam logic [7:0] OFS_CONFIG = 8'h94;
  localparam logic [7:0] OFS_SLOT = 8'h95;
  localparam logic [7:0] OFS_STATUS = 8'h96;
  localparam logic [7:0] CONFIG_RESET = 8'h00;
  localparam logic [7:0] SLOT_RESET = 8'h00;
  // interleave config field positions
  localparam int POS_ENABLE = 3;
  localparam int POS_TYPE = 2;
  localparam int POS_MSEL_LOW = 1;
  localparam int POS_MSEL_HIGH = 0;
  // slot register field positions
  localparam int POS_SLOT_LO = 0;
  localparam int POS_SLOT_HI = 1;
  localparam int POS_QUAD = 2;
  // master select codes {high, low}
  localparam logic [1:0] MSEL_SLAVE = 2'h0;
  localparam logic [1:0] MSEL_MASTER_TWO = 2'h1;
  localparam logic [1:0] MSEL_MASTER_FOUR = 2'h2;
  // bus geometry
  localparam int CHAN_W = 5;
  localparam int MEM_DEPTH = 32;
  localparam int MEM_W = 12;
  localparam int CNT_W = 10;
  localparam logic [9:0] LAST_BIT_TWO = 10'h1FF;
  localparam logic [9:0] LAST_BIT_FOUR = 10'h3FF;
  typedef enum logic [0:0] {IPBB_WAIT_SYNC, IPBB_RUN} ipbb_state_t;
endpackage : ipbb_pkg

// >>> design/ipbb_frame_mem.sv
// one-frame channel store with registered read data
`timescale 1ns/1ps
module ipbb_frame_mem
  import ipbb_pkg::*;
(
  input wire logic ref_clk,
  input wire logic wr_en,
  input wire logic [CHAN_W-1:0] wr_addr,
  input wire logic [MEM_W-1:0] wr_data,
  input wire logic [CHAN_W-1:0] rd_addr,
  output logic [MEM_W-1:0] rd_data
);
  logic [MEM_W-1:0] mem [MEM_DEPTH];

  // write port; contents need no reset, the framer refills every frame
  always_ff @(posedge ref_clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  // read data always come out of a register
  always_ff @(posedge ref_clk) begin
    rd_data <= mem[rd_addr];
  end
endmodule : ipbb_frame_mem

// >>> design/ipbb_top.sv
// one framer's end of the interleaved backplane data and signaling buses
//
// Behaviour
// - framer data and signaling bytes are multiplexed onto shared serial buses
// - at 4.096 MHz two framers share the bus, two slots
// - at 8.192 MHz four framers share the bus, four slots
// - type bit 0 interleaves by byte, 1 interleaves by frame
// - exactly one master per bus, all others slaves
// - 4.096 MHz bus has one master and one slave
// - 8.192 MHz bus has one master and three slaves
// - enable bit 0 turns interleaving off, 1 turns it on
// - master select 00 slave, 01 master of two, 10 master of four, 11 reserved
//
// Decided for this implementation: the strobed register port.
`timescale 1ns/1ps
module ipbb_top
  import ipbb_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [DATA_W-1:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [DATA_W-1:0] reg_rdata,
  input wire logic sys_wr_en,
  input wire logic [CHAN_W-1:0] sys_wr_chan,
  input wire logic [7:0] sys_wr_data,
  input wire logic [3:0] sys_wr_sig,
  input wire logic bus_clk,
  input wire logic receive_sync_pulse,
  output logic bus_sync_out,
  output logic bus_sync_oe,
  output logic bus_data_out,
  output logic bus_data_oe,
  output logic bus_sig_out,
  output logic bus_sig_oe
);
  logic [7:0] config_reg;
  logic [7:0] slot_reg;
  logic [1:0] clk_sync_reg;
  logic clk_prev_reg;
  logic [1:0] fs_sync_reg;
  logic fs_prev_reg;
  logic [CNT_W-1:0] bit_cnt_reg;
  ipbb_state_t state_reg;
  logic [MEM_W-1:0] mem_q;
  logic [CHAN_W-1:0] rd_chan;
  logic bus_edge;
  logic fs_edge;
  logic enabled;
  logic is_master;
  logic quad;
  logic frame_mode;
  logic [1:0] own_slot;
  logic [1:0] cur_slot;
  logic [CNT_W-1:0] last_bit;
  logic [2:0] bit_idx;
  logic own_turn;

  // slot number that owns a given bus bit
  function automatic logic [1:0] slot_of(input logic [CNT_W-1:0] cnt, input logic fmode, input logic q4);
    logic [1:0] s;
    s = 2'h0;
    if (fmode) begin
      s = q4 ? cnt[9:8] : {1'b0, cnt[8]};
    end else begin
      s = q4 ? cnt[4:3] : {1'b0, cnt[3]};
    end
    return s;
  endfunction : slot_of

  // framer channel carried by a given bus bit
  function automatic logic [CHAN_W-1:0] chan_of(input logic [CNT_W-1:0] cnt, input logic fmode, input logic q4);
    logic [CHAN_W-1:0] c;
    c = 5'h00;
    if (fmode) begin
      c = cnt[7:3];
    end else begin
      c = q4 ? cnt[9:5] : cnt[8:4];
    end
    return c;
  endfunction : chan_of

  // enable gate
  // a reserved select code keeps the block off the bus entirely
  assign enabled = config_reg[POS_ENABLE] &&
                   ({config_reg[POS_MSEL_HIGH], config_reg[POS_MSEL_LOW]} != 2'h3);
  assign is_master = ({config_reg[POS_MSEL_HIGH], config_reg[POS_MSEL_LOW]} == MSEL_MASTER_TWO) ||
                     ({config_reg[POS_MSEL_HIGH], config_reg[POS_MSEL_LOW]} == MSEL_MASTER_FOUR);
  // master of four leaves slots one to three to its three slaves
  // four-way bus chosen by master code, or by slot register on a slave
  assign quad = ({config_reg[POS_MSEL_HIGH], config_reg[POS_MSEL_LOW]} == MSEL_MASTER_FOUR) ||
                (!is_master && slot_reg[POS_QUAD]);
  assign frame_mode = config_reg[POS_TYPE];
  // the master always owns slot zero
  assign own_slot = is_master ? 2'h0 : {slot_reg[POS_SLOT_HI], slot_reg[POS_SLOT_LO]};
  // bus frame length follows the framer count
  // two-way frame holds one master slot, one slave slot
  assign last_bit = quad ? LAST_BIT_FOUR : LAST_BIT_TWO;
  assign cur_slot = slot_of(bit_cnt_reg, frame_mode, quad);
  assign rd_chan = chan_of(bit_cnt_reg, frame_mode, quad);
  assign bit_idx = bit_cnt_reg[2:0];
  assign own_turn = enabled && (state_reg == IPBB_RUN) && (cur_slot == own_slot);
  assign bus_edge = clk_sync_reg[1] && !clk_prev_reg;
  assign fs_edge = fs_sync_reg[1] && !fs_prev_reg;

  // two-stage synchronisers for bus clock and frame sync pins
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      clk_sync_reg <= 2'h0;
      clk_prev_reg <= 1'b0;
      fs_sync_reg <= 2'h0;
      fs_prev_reg <= 1'b0;
    end else begin
      clk_sync_reg <= {clk_sync_reg[0], bus_clk};
      clk_prev_reg <= clk_sync_reg[1];
      fs_sync_reg <= {fs_sync_reg[0], receive_sync_pulse};
      fs_prev_reg <= fs_sync_reg[1];
    end
  end

  // register writes; upper bits are stored as written and read back
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      config_reg <= CONFIG_RESET;
      slot_reg <= SLOT_RESET;
    end else if (reg_write) begin
      if (reg_addr == OFS_CONFIG) begin
        config_reg <= reg_wdata;
      end else if (reg_addr == OFS_SLOT) begin
        slot_reg <= reg_wdata;
      end
    end
  end

  // read data valid the cycle after the strobe; unmapped reads give zero
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= 8'h00;
    end else if (reg_read) begin
      if (reg_addr == OFS_CONFIG) begin
        reg_rdata <= config_reg;
      end else if (reg_addr == OFS_SLOT) begin
        reg_rdata <= slot_reg;
      end else if (reg_addr == OFS_STATUS) begin
        reg_rdata <= {4'h0, own_turn, cur_slot, state_reg == IPBB_RUN};
      end else begin
        reg_rdata <= 8'h00;
      end
    end else begin
      reg_rdata <= 8'h00;
    end
  end

  // sync state: master runs free, slave waits for the frame sync input
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= IPBB_WAIT_SYNC;
    end else begin
      case (state_reg)
        IPBB_WAIT_SYNC: begin
          if (enabled && (is_master || fs_edge)) begin
            state_reg <= IPBB_RUN;
          end
        end
        IPBB_RUN: begin
          if (!enabled) begin
            state_reg <= IPBB_WAIT_SYNC;
          end
        end
        default: begin
          state_reg <= IPBB_WAIT_SYNC;
        end
      endcase
    end
  end

  // bus bit counter; a slave realigns to every frame sync it sees
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      bit_cnt_reg <= 10'h000;
    end else if (!enabled) begin
      bit_cnt_reg <= 10'h000;
    end else if (!is_master && fs_edge) begin
      bit_cnt_reg <= 10'h000;
    end else if (bus_edge) begin
      bit_cnt_reg <= (bit_cnt_reg == last_bit) ? 10'h000 : bit_cnt_reg + 10'h001;
    end
  end

  // serialise own slot msb first; memory read settles between bus edges
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      bus_data_out <= 1'b0;
      bus_data_oe <= 1'b0;
      bus_sig_out <= 1'b0;
      bus_sig_oe <= 1'b0;
      bus_sync_out <= 1'b0;
      bus_sync_oe <= 1'b0;
    end else if (!enabled) begin
      bus_data_oe <= 1'b0;
      bus_sig_oe <= 1'b0;
      bus_sync_oe <= 1'b0;
      bus_sync_out <= 1'b0;
    end else if (bus_edge) begin
      bus_data_out <= mem_q[4'hB - {1'b0, bit_idx}];
      bus_sig_out <= (bit_idx < 3'h4) ? 1'b0 : mem_q[3'h7 - bit_idx];
      bus_data_oe <= own_turn;
      bus_sig_oe <= own_turn;
      // only the master drives the shared frame sync
      bus_sync_oe <= is_master;
      bus_sync_out <= is_master && (state_reg == IPBB_RUN) && (bit_cnt_reg == 10'h000);
    end
  end

  // store packs {data, signaling} per channel
  ipbb_frame_mem u_mem (
    .ref_clk(ref_clk),
    .wr_en(sys_wr_en),
    .wr_addr(sys_wr_chan),
    .wr_data({sys_wr_data, sys_wr_sig}),
    .rd_addr(rd_chan),
    .rd_data(mem_q)
  );
endmodule : ipbb_top

// >>> verif/ipbb_bus_partner.sv
// backplane partner: bus clock and frame sync from the other framers
`timescale 1ns/1ps
module ipbb_bus_partner (
  output logic bus_clk,
  output logic receive_sync_pulse
);
  int n;
  // one clock reference shared by every framer
  initial begin
    bus_clk = 1'b0;
    receive_sync_pulse = 1'b0;
    n = 0;
  end
  always #100 bus_clk = ~bus_clk;
  // sync is an input, one pulse per 512-bit frame
  always @(negedge bus_clk) begin
    n <= (n + 1) % 512;
    receive_sync_pulse <= (n == 0);
  end
endmodule : ipbb_bus_partner

// >>> verif/ipbb_top_properties.sv
// port checks for the interleaved bus block
`timescale 1ns/1ps
module ipbb_top_properties
  import ipbb_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [DATA_W-1:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  input wire logic [DATA_W-1:0] reg_rdata,
  input wire logic bus_sync_out,
  input wire logic bus_sync_oe,
  input wire logic bus_data_oe,
  input wire logic bus_sig_oe
);
  logic [7:0] cfg_reg;
  logic [13:0] age_reg;
  logic [13:0] gap_reg;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  // config shadow and cycles since its last write
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cfg_reg <= CONFIG_RESET;
      age_reg <= 14'h0000;
    end else if (reg_write && reg_addr == OFS_CONFIG) begin
      cfg_reg <= reg_wdata;
      age_reg <= 14'h0000;
    end else if (age_reg != 14'h3FFF) begin
      age_reg <= age_reg + 14'h0001;
    end
  end
  // cycles between sync pulses, saturating so a lost pulse still fails
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      gap_reg <= 14'h3FFF;
    end else if ($rose(bus_sync_out)) begin
      gap_reg <= 14'h0001;
    end else if (gap_reg != 14'h3FFF) begin
      gap_reg <= gap_reg + 14'h0001;
    end
  end
  a_cfg_read_back: assert property (reg_read && reg_addr == OFS_CONFIG |=> reg_rdata == cfg_reg)
    else $error("config read differs");
  a_off_no_drive: assert property (age_reg > 14'h003F && !cfg_reg[3] |->
    !(bus_data_oe || bus_sig_oe || bus_sync_oe)) else $error("driven while off");
  a_resv_no_drive: assert property (age_reg > 14'h003F && cfg_reg[1:0] == 2'h3 |->
    !(bus_data_oe || bus_sig_oe || bus_sync_oe)) else $error("driven with reserved code");
  a_slave_no_sync: assert property (age_reg > 14'h003F && cfg_reg[1:0] == 2'h0 |-> !bus_sync_oe)
    else $error("slave drives sync");
  a_master_has_sync: assert property (age_reg > 14'h003F && cfg_reg[3] && ^cfg_reg[1:0] |-> bus_sync_oe)
    else $error("master not driving sync");
  a_sync_one_bit: assert property ($rose(bus_sync_out) && age_reg > 14'h003F |->
    bus_sync_out [*6] ##[1:4] !bus_sync_out) else $error("sync not one bus bit");
  a_frame_of_two: assert property ($rose(bus_sync_out) && age_reg > 14'h2328 && cfg_reg[3] && cfg_reg[1:0] == 2'h2 |->
    gap_reg inside {[14'h0FFE:14'h1002]}) else $error("two framer period wrong");
  a_frame_of_four: assert property ($rose(bus_sync_out) && age_reg > 14'h2328 && cfg_reg[3] && cfg_reg[1:0] == 2'h1 |->
    gap_reg inside {[14'h1FFE:14'h2002]}) else $error("four framer period wrong");
endmodule : ipbb_top_properties

bind ipbb_top ipbb_top_properties u_props (.ref_clk(ref_clk), .rst_n(rst_n), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
  .bus_sync_out(bus_sync_out), .bus_sync_oe(bus_sync_oe), .bus_data_oe(bus_data_oe), .bus_sig_oe(bus_sig_oe));

// >>> verif/ipbb_top_tb.sv
// self-checking bench for the interleaved bus block
`timescale 1ns/1ps
module ipbb_top_tb
  import ipbb_pkg::*;
;
  logic ref_clk = 1'b0, rst_n = 1'b0, reg_write = 1'b0, reg_read = 1'b0, sys_wr_en = 1'b0, seen;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, sys_wr_data = 8'h00, reg_rdata, d0;
  logic [4:0] sys_wr_chan = 5'h00;
  logic [3:0] sys_wr_sig = 4'h0;
  logic bus_clk, receive_sync_pulse, bus_sync_out, bus_sync_oe, bus_data_out, bus_data_oe, bus_sig_out, bus_sig_oe;
  logic [23:0] dv, ov, sv;
  logic [31:0] lfsr = 32'h0000E597;
  // master of two by byte, of two by frame, of four by byte, of four by frame
  logic [7:0] modes [4] = '{8'h0A, 8'h0E, 8'h09, 8'h0D};
  int failures = 0, n_compared = 0;
  always #12.5 ref_clk = ~ref_clk;
  ipbb_top dut (.ref_clk(ref_clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata), .sys_wr_en(sys_wr_en),
    .sys_wr_chan(sys_wr_chan), .sys_wr_data(sys_wr_data), .sys_wr_sig(sys_wr_sig), .bus_clk(bus_clk),
    .receive_sync_pulse(receive_sync_pulse), .bus_sync_out(bus_sync_out), .bus_sync_oe(bus_sync_oe),
    .bus_data_out(bus_data_out), .bus_data_oe(bus_data_oe), .bus_sig_out(bus_sig_out), .bus_sig_oe(bus_sig_oe));
  ipbb_bus_partner partner (.bus_clk(bus_clk), .receive_sync_pulse(receive_sync_pulse));
  function automatic logic [31:0] step(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction : step
  task automatic check(input string what, input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      failures++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask : check
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge ref_clk);
    reg_write <= 1'b0;
    @(posedge ref_clk);
  endtask : wr
  // read data stands only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string what);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge ref_clk);
    reg_read <= 1'b0;
    #1;
    check(what, reg_rdata, exp);
    @(posedge ref_clk);
  endtask : rd
  task automatic st(input logic [4:0] c, input logic [7:0] d, input logic [3:0] s);
    sys_wr_en <= 1'b1;
    sys_wr_chan <= c;
    sys_wr_data <= d;
    sys_wr_sig <= s;
    @(posedge ref_clk);
    sys_wr_en <= 1'b0;
    @(posedge ref_clk);
  endtask : st
  // 24 bus bits from frame start, sampled mid-bit on the falling edge
  task automatic grab();
    @(posedge bus_sync_out);
    repeat (2) @(negedge ref_clk);
    for (int i = 23; i >= 0; i--) begin
      dv[i] = bus_data_out;
      ov[i] = bus_data_oe;
      sv[i] = bus_sig_out;
      @(posedge bus_clk);
      repeat (6) @(negedge ref_clk);
    end
    @(posedge ref_clk);
  endtask : grab
  task automatic give_verdict();
    if (failures == 0 && n_compared > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : give_verdict
  initial begin
    repeat (4) @(posedge ref_clk);
    rst_n <= 1'b1;
    @(posedge ref_clk);
    rd(OFS_CONFIG, CONFIG_RESET, "cfg reset");
    for (int k = 0; k < 4; k++) begin
      lfsr = step(lfsr);
      // upper bits always written as zero
      wr(OFS_CONFIG, {5'h00, lfsr[2:0]});
      rd(OFS_CONFIG, {5'h00, lfsr[2:0]}, "cfg");
    end
    wr(8'h97, 8'hFF);
    rd(8'h97, 8'h00, "unmapped");
    d0 = lfsr[10:3];
    // store filled before interleave is on
    st(5'h00, d0, lfsr[14:11]);
    st(5'h01, 8'h80, 4'h0);
    foreach (modes[m]) begin
      wr(OFS_CONFIG, modes[m]);
      grab();
      check("ch0 data", dv[23:16], d0);
      check("ch0 sig", sv[23:16], {4'h0, lfsr[14:11]});
      check("slot1 oe", ov[15:8], modes[m][2] ? 8'hFF : 8'h00);
      check("byte2 oe", ov[7:0], (modes[m][0] && !modes[m][2]) ? 8'h00 : 8'hFF);
      if (modes[m][2] || !modes[m][0]) check("ch1 data", modes[m][2] ? dv[15:8] : dv[7:0], 8'h80);
      // long enough for at least one frame pulse after the config has aged past the period checks
      repeat (modes[m][0] ? 17300 : 13200) @(posedge ref_clk);
    end
    for (int q = 0; q < 2; q++) begin
      wr(OFS_CONFIG, q ? 8'h07 : 8'h0B);
      repeat (100) @(negedge ref_clk);
      check("quiet oe", {5'h00, bus_sync_oe, bus_data_oe, bus_sig_oe}, 8'h00);
      @(posedge ref_clk);
    end
    wr(OFS_SLOT, 8'h01);
    wr(OFS_CONFIG, 8'h08);
    seen = 1'b0;
    repeat (5000) @(negedge ref_clk) seen = seen | bus_data_oe;
    check("slave drives", {7'h00, seen}, 8'h01);
    give_verdict();
  end
  // watchdog sized from the four long frame holds plus setup
  initial begin
    repeat (98000) @(posedge ref_clk);
    failures++;
    give_verdict();
  end
endmodule : ipbb_top_tb
